// *** ser_pkg.sv ***
// package of constants, commands and bit layouts for status event reporting
// =====================================================================
// What this block does
// RULE_01 - queries answer with the decimal weighted sum
// RULE_02 - only enable registers accept host writes
// RULE_03 - decimal write loads matching binary bits
// RULE_04 - condition register follows live inputs, never cleared
// RULE_05 - standard event query returns then clears
// RULE_06 - clear-status clears both event registers together
// RULE_07 - reset clears events, enables and status byte
// RULE_08 - writing zero clears an enable register
// RULE_09 - status byte only clears via event registers; bit four follows msgAvailable and clears when it drops
// RULE_10 - reading standard events drops summary bit five
// RULE_11 - standard mask command; enabled events set summary
// RULE_12 - standard bit seven marks power-on transition
// RULE_13 - standard bit five flags uninterpretable commands
// RULE_14 - standard bit four flags execution errors
// RULE_15 - standard bit two flags lost response data
// RULE_16 - bit zero sets when pending work finishes
// RULE_17 - operation mask, event and condition queries
// RULE_18 - operation bit seven: processor link failure
// RULE_19 - operation bit six: calibration missing or corrupt
// RULE_20 - operation bit five: tuning not running
// RULE_21 - bit four new reading, bit one overrange
// RULE_22 - bit zero: alarm while alarm display on
// RULE_23 - event bits latch until query or clear
// RULE_24 - summary is OR of event AND enable
// RULE_25 - operation summary bit seven, standard summary five
// RULE_26 - enabled summary sets bit six and service request
// RULE_27 - unused bits read zero, ignore writes
package ser_pkg;

  typedef enum logic [3:0] {
    SER_CMD_CLS,
    SER_CMD_OPC,
    SER_CMD_STD_MASK_WR,
    SER_CMD_STD_MASK_RD,
    SER_CMD_STD_EVENT_RD,
    SER_CMD_SRQ_MASK_WR,
    SER_CMD_SRQ_MASK_RD,
    SER_CMD_STB_RD,
    SER_CMD_OP_MASK_WR,
    SER_CMD_OP_MASK_RD,
    SER_CMD_OP_EVENT_RD,
    SER_CMD_OP_COND_RD
  } ser_cmd_t;

  // =====================================================================
  // standard event register bits
  localparam int SER_STD_PON    = 7;
  localparam int SER_STD_CMDERR = 5;
  localparam int SER_STD_EXEERR = 4;
  localparam int SER_STD_QRYERR = 2;
  localparam int SER_STD_OPDONE = 0;
  localparam logic [7:0] SER_STD_USED = 8'hb5;

  // =====================================================================
  // operation register bits
  localparam int SER_OP_COMM     = 7;
  localparam int SER_OP_CAL      = 6;
  localparam int SER_OP_TUNE     = 5;
  localparam int SER_OP_READING  = 4;
  localparam int SER_OP_OVERLOAD = 1;
  localparam int SER_OP_ALARM    = 0;
  localparam logic [7:0] SER_OP_USED = 8'hf3;

  // =====================================================================
  // status byte bits
  localparam int SER_STB_OSB = 7;
  localparam int SER_STB_MSS = 6;
  localparam int SER_STB_ESB = 5;
  localparam int SER_STB_MAV = 4;
  localparam logic [7:0] SER_SRQ_USED = 8'hb0;

  // =====================================================================
  // reset values
  localparam logic [7:0] SER_REG_RESET = 8'h00;
  localparam logic       SER_PON_RESET = 1'b1;

endpackage

// *** ser_bin_to_dec.sv ***
// binary byte to three decimal digits for query answers
`timescale 1ns/1ps
module ser_bin_to_dec
  import ser_pkg::*;
(
  input  wire logic [7:0]  value,
  output logic      [11:0] digits
);

  logic [7:0] hundreds;
  logic [7:0] rest;
  logic [7:0] tens;
  logic [7:0] units;

  // constant divisors keep this a small combinational tree
  always_comb begin
    hundreds = value / 8'h64;
    rest     = value - 8'((hundreds * 8'h64));
    tens     = rest / 8'h0a;
    units    = rest - 8'((tens * 8'h0a));
    digits   = {hundreds[3:0], tens[3:0], units[3:0]};
  end

endmodule

// *** ser_dec_to_bin.sv ***
// three decimal digits to a byte, flagging bad digits or overrange
`timescale 1ns/1ps
module ser_dec_to_bin
  import ser_pkg::*;
(
  input  wire logic [11:0] digits,
  output logic      [7:0]  value,
  output logic             bad
);

  logic [9:0] sum;

  always_comb begin
    sum   = 10'(digits[11:8]) * 10'h064 + 10'(digits[7:4]) * 10'h00a
            + 10'(digits[3:0]);
    value = sum[7:0];
    bad   = (digits[11:8] > 4'h9) || (digits[7:4] > 4'h9) ||
            (digits[3:0] > 4'h9) || (sum > 10'h0ff);
  end

endmodule

// *** ser_status_event_reporting.sv ***
// status byte, standard event and operation register sets with service request
`timescale 1ns/1ps
module ser_status_event_reporting
  import ser_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        cmdValid,
  input  wire ser_cmd_t    cmdCode,
  input  wire logic [11:0] cmdDigits,
  output logic             respValid,
  output logic      [11:0] respDigits,
  input  wire logic        commandError,
  input  wire logic        executionError,
  input  wire logic        queryError,
  input  wire logic        operationsPending,
  input  wire logic        procCommFail,
  input  wire logic        calFault,
  input  wire logic        tuningIdle,
  input  wire logic        newReading,
  input  wire logic        sensorOverrange,
  input  wire logic        alarmActive,
  input  wire logic        alarmDisplayOn,
  input  wire logic        msgAvailable,
  input  wire logic        serialPoll,
  output logic      [7:0]  statusByte,
  output logic      [7:0]  pollByte,
  output logic             srq
);

  // =====================================================================
  // state
  logic [7:0] stdEvents;
  logic [7:0] stdMask;
  logic [7:0] opEvents;
  logic [7:0] opMask;
  logic [7:0] srqMask;
  logic [7:0] opCondition;
  logic [7:0] respValue;
  logic [7:0] writeValue;
  logic       writeBad;
  logic       ponPending;
  logic       opcArmed;
  logic       mss;
  logic       mssLast;
  logic       rqs;
  logic [7:0] next_stdSet;
  logic [7:0] next_summaryByte;
  logic       clrStd;
  logic       clrOp;
  logic       isWrite;

  function automatic logic cmd_is(input logic v, input ser_cmd_t c, input ser_cmd_t want);
    return v && (c == want);
  endfunction

  ser_dec_to_bin u_dec_to_bin (
    .digits (cmdDigits),
    .value  (writeValue),
    .bad    (writeBad)
  );

  ser_bin_to_dec u_bin_to_dec (
    .value  (respValue),
    .digits (respDigits)
  );

  // =====================================================================
  // condition register, a live view of the instrument
  always_comb begin
    opCondition                   = SER_REG_RESET; // RULE_27
    opCondition[SER_OP_COMM]      = procCommFail; // RULE_04 RULE_18
    opCondition[SER_OP_CAL]       = calFault; // RULE_19
    opCondition[SER_OP_TUNE]      = tuningIdle; // RULE_20
    opCondition[SER_OP_READING]   = newReading; // RULE_21
    opCondition[SER_OP_OVERLOAD]  = sensorOverrange; // RULE_21
    opCondition[SER_OP_ALARM]     = alarmActive && alarmDisplayOn; // RULE_22
  end

  // =====================================================================
  // command decode
  always_comb begin
    clrStd  = cmd_is(cmdValid, cmdCode, SER_CMD_STD_EVENT_RD) ||
              cmd_is(cmdValid, cmdCode, SER_CMD_CLS); // RULE_05 RULE_06
    clrOp   = cmd_is(cmdValid, cmdCode, SER_CMD_OP_EVENT_RD) ||
              cmd_is(cmdValid, cmdCode, SER_CMD_CLS); // RULE_06 RULE_17
    isWrite = cmd_is(cmdValid, cmdCode, SER_CMD_STD_MASK_WR) ||
              cmd_is(cmdValid, cmdCode, SER_CMD_SRQ_MASK_WR) ||
              cmd_is(cmdValid, cmdCode, SER_CMD_OP_MASK_WR);
  end

  // an out-of-range write value counts as an execution error
  always_comb begin
    next_stdSet                 = SER_REG_RESET;
    next_stdSet[SER_STD_PON]    = ponPending; // RULE_12
    next_stdSet[SER_STD_CMDERR] = commandError; // RULE_13
    next_stdSet[SER_STD_EXEERR] = executionError || (isWrite && writeBad); // RULE_14
    next_stdSet[SER_STD_QRYERR] = queryError; // RULE_15
    next_stdSet[SER_STD_OPDONE] = opcArmed && !operationsPending; // RULE_16
  end

  // =====================================================================
  // power-on marker: caught on the first edge after reset release
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ponPending <= SER_PON_RESET;
    end else begin
      ponPending <= 1'b0;
    end
  end

  // operation-complete arming; finished work or clear-status disarms this
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opcArmed <= 1'b0;
    end else if (cmd_is(cmdValid, cmdCode, SER_CMD_OPC)) begin
      opcArmed <= 1'b1; // RULE_16
    end else if (opcArmed && !operationsPending) begin
      opcArmed <= 1'b0;
    end else if (cmd_is(cmdValid, cmdCode, SER_CMD_CLS)) begin
      opcArmed <= 1'b0;
    end
  end

  // =====================================================================
  // event registers: set wins over a clear in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stdEvents <= SER_REG_RESET; // RULE_07
    end else if (clrStd) begin
      stdEvents <= next_stdSet & SER_STD_USED; // RULE_05 RULE_06
    end else begin
      stdEvents <= (stdEvents | next_stdSet) & SER_STD_USED; // RULE_23 RULE_27
    end
  end

  // level-sensitive: a condition still present re-sets its bit after a clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opEvents <= SER_REG_RESET; // RULE_07
    end else if (clrOp) begin
      opEvents <= opCondition & SER_OP_USED; // RULE_06 RULE_17
    end else begin
      opEvents <= (opEvents | opCondition) & SER_OP_USED; // RULE_23 RULE_27
    end
  end

  // =====================================================================
  // enable registers, the only host-writable state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stdMask <= SER_REG_RESET; // RULE_07
      opMask  <= SER_REG_RESET;
      srqMask <= SER_REG_RESET;
    end else if (!writeBad) begin
      if (cmd_is(cmdValid, cmdCode, SER_CMD_STD_MASK_WR)) begin
        stdMask <= writeValue & SER_STD_USED; // RULE_02 RULE_03 RULE_08 RULE_11
      end else if (cmd_is(cmdValid, cmdCode, SER_CMD_OP_MASK_WR)) begin
        opMask <= writeValue & SER_OP_USED; // RULE_03 RULE_08 RULE_17
      end else if (cmd_is(cmdValid, cmdCode, SER_CMD_SRQ_MASK_WR)) begin
        srqMask <= writeValue & SER_SRQ_USED; // RULE_03 RULE_08 RULE_27
      end
    end
  end

  // =====================================================================
  // query answers, one cycle after the command
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      respValid <= 1'b0;
      respValue <= SER_REG_RESET;
    end else begin
      respValid <= 1'b0;
      if (cmdValid) begin
        respValid <= 1'b1;
        case (cmdCode)
          SER_CMD_STD_MASK_RD:  respValue <= stdMask; // RULE_11
          SER_CMD_STD_EVENT_RD: respValue <= stdEvents; // RULE_01 RULE_05
          SER_CMD_SRQ_MASK_RD:  respValue <= srqMask;
          SER_CMD_STB_RD:       respValue <= statusByte;
          SER_CMD_OP_MASK_RD:   respValue <= opMask; // RULE_17
          SER_CMD_OP_EVENT_RD:  respValue <= opEvents; // RULE_17
          SER_CMD_OP_COND_RD:   respValue <= opCondition; // RULE_04 RULE_17
          default: begin
            respValid <= 1'b0;
          end
        endcase
      end
    end
  end

  // =====================================================================
  // status byte: non-latching summaries, registered for clean outputs
  always_comb begin
    next_summaryByte              = SER_REG_RESET;
    next_summaryByte[SER_STB_OSB] = |(opEvents & opMask); // RULE_24 RULE_25
    next_summaryByte[SER_STB_ESB] = |(stdEvents & stdMask); // RULE_10 RULE_24 RULE_25
    next_summaryByte[SER_STB_MAV] = msgAvailable;
    mss                           = |(next_summaryByte & srqMask); // RULE_26
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      statusByte <= SER_REG_RESET; // RULE_07
      mssLast    <= 1'b0;
    end else begin
      statusByte              <= next_summaryByte; // RULE_09
      statusByte[SER_STB_MSS] <= mss; // RULE_26
      mssLast                 <= mss;
    end
  end

  // request flag: a fresh rise wins over a poll in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rqs <= 1'b0;
    end else if (mss && !mssLast) begin
      rqs <= 1'b1; // RULE_26
    end else if (serialPoll || !mss) begin
      rqs <= 1'b0;
    end
  end

  always_comb begin
    srq                   = rqs;
    pollByte              = statusByte;
    pollByte[SER_STB_MSS] = rqs;
  end

  // =====================================================================
  // checks
  a_std_read_value: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
    cmd_is(cmdValid, cmdCode, SER_CMD_STD_EVENT_RD) |=> respValid && respValue == $past(stdEvents))
    else $error("standard event query returned the wrong value");

  a_std_read_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE_05
    clrStd && next_stdSet == 8'h00 |=> stdEvents == 8'h00)
    else $error("standard event register not cleared by query");

  a_cls_both_clear: assert property (@(posedge sys_clk) disable iff (rst) // RULE_06
    cmd_is(cmdValid, cmdCode, SER_CMD_CLS) && next_stdSet == 8'h00 && opCondition == 8'h00
    |=> stdEvents == 8'h00 && opEvents == 8'h00 ##1 statusByte[SER_STB_ESB] == 1'b0)
    else $error("clear-status left an event or summary bit set");

  a_event_latch_hold: assert property (@(posedge sys_clk) disable iff (rst) // RULE_23
    !clrStd && !clrOp |=> (stdEvents & $past(stdEvents)) == $past(stdEvents) &&
    (opEvents & $past(opEvents)) == $past(opEvents))
    else $error("event bit dropped without a clear");

  a_cond_live: assert property (@(posedge sys_clk) disable iff (rst) // RULE_04
    cmd_is(cmdValid, cmdCode, SER_CMD_OP_COND_RD) |=> respValue ==
    $past({procCommFail, calFault, tuningIdle, newReading, 2'b00, sensorOverrange,
    alarmActive && alarmDisplayOn}))
    else $error("condition query not live");

  a_mask_write: assert property (@(posedge sys_clk) disable iff (rst) // RULE_03
    cmd_is(cmdValid, cmdCode, SER_CMD_STD_MASK_WR) && !writeBad
    |=> stdMask == ($past(writeValue) & SER_STD_USED))
    else $error("standard mask not loaded from decimal write");

  a_summary_bits: assert property (@(posedge sys_clk) disable iff (rst) // RULE_24
    1'b1 |=> statusByte[SER_STB_ESB] == $past(|(stdEvents & stdMask)) &&
    statusByte[SER_STB_OSB] == $past(|(opEvents & opMask)))
    else $error("summary bit does not follow enabled events");

  a_srq_raise: assert property (@(posedge sys_clk) disable iff (rst) // RULE_26
    mss && !mssLast |=> srq && statusByte[SER_STB_MSS])
    else $error("service request not raised on new summary");

  a_poll_clears_rqs: assert property (@(posedge sys_clk) disable iff (rst) // RULE_26
    serialPoll && !(mss && !mssLast) |=> !srq)
    else $error("serial poll did not clear the request");

  a_power_on_bit: assert property (@(posedge sys_clk) disable iff (rst) // RULE_12
    ponPending |=> stdEvents[SER_STD_PON])
    else $error("power-on bit not set after reset release");

  a_opc_done: assert property (@(posedge sys_clk) disable iff (rst) // RULE_16
    opcArmed && !operationsPending && !cmd_is(cmdValid, cmdCode, SER_CMD_OPC)
    |=> stdEvents[SER_STD_OPDONE] && !opcArmed)
    else $error("operation-complete bit not set when work finished");

endmodule

// *** ser_host_model.sv ***
// host-side bus controller model that issues status commands and collects answers
`timescale 1ns/1ps
module ser_host_model
  import ser_pkg::*;
(
  input  wire logic        sys_clk,
  output logic             cmdValid,
  output ser_cmd_t         cmdCode,
  output logic      [11:0] cmdDigits,
  input  wire logic        respValid,
  input  wire logic [11:0] respDigits
);
  initial begin
    cmdValid  = 1'b0;
    cmdCode   = SER_CMD_STB_RD;
    cmdDigits = 12'h000;
  end

  // =====================================================================
  // decimal text on the bus travels here as three bcd digits
  function automatic logic [11:0] to_bcd(input int v);
    return {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
  endfunction

  function automatic logic [7:0] from_bcd(input logic [11:0] d);
    return 8'(d[11:8] * 100 + d[7:4] * 10 + d[3:0]);
  endfunction

  // =====================================================================
  // digits are scrambled after release so a stale value is never mistaken for a fresh one
  task automatic issue(input ser_cmd_t code, input int value);
    cmdCode   = code;
    cmdDigits = to_bcd(value);
    cmdValid  = 1'b1;
    @(posedge sys_clk);
    #1;
    cmdValid  = 1'b0;
    cmdDigits = ~cmdDigits;
  endtask

  task automatic query(input ser_cmd_t code, output logic [7:0] val, output logic ok);
    int n;
    issue(code, 0);
    n = 0;
    while (respValid !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    ok  = respValid;
    val = from_bcd(respDigits);
  endtask
endmodule

// *** test_status_event_reporting.sv ***
// self-checking bench for the status event reporting block
`timescale 1ns/1ps
module test_status_event_reporting
  import ser_pkg::*;
;
  typedef struct {ser_cmd_t wr; ser_cmd_t rd; int val; logic [7:0] exp;} ser_row_t;

  logic        sys_clk, rst, cmdValid, respValid;
  ser_cmd_t    cmdCode;
  logic [11:0] cmdDigits, respDigits;
  logic        commandError, executionError, queryError, operationsPending;
  logic        procCommFail, calFault, tuningIdle, newReading, sensorOverrange;
  logic        alarmActive, alarmDisplayOn, msgAvailable, serialPoll, srq;
  logic [7:0]  statusByte, pollByte;
  int          errTotal     = 0;
  int          totalChecks  = 0;

  ser_row_t rows [7] = '{
    '{SER_CMD_STD_MASK_WR, SER_CMD_STD_MASK_RD, 255, 8'hb5},
    '{SER_CMD_STD_MASK_WR, SER_CMD_STD_MASK_RD, 0,   8'h00},
    '{SER_CMD_STD_MASK_WR, SER_CMD_STD_MASK_RD, 21,  8'h15},
    '{SER_CMD_OP_MASK_WR,  SER_CMD_OP_MASK_RD,  255, 8'hf3},
    '{SER_CMD_OP_MASK_WR,  SER_CMD_OP_MASK_RD,  12,  8'h00},
    '{SER_CMD_SRQ_MASK_WR, SER_CMD_SRQ_MASK_RD, 255, 8'hb0},
    '{SER_CMD_SRQ_MASK_WR, SER_CMD_SRQ_MASK_RD, 32,  8'h20}
  };

  ser_status_event_reporting ser_status_event_reporting_inst (
    .sys_clk(sys_clk), .rst(rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdDigits(cmdDigits), .respValid(respValid), .respDigits(respDigits),
    .commandError(commandError), .executionError(executionError), .queryError(queryError),
    .operationsPending(operationsPending), .procCommFail(procCommFail), .calFault(calFault),
    .tuningIdle(tuningIdle), .newReading(newReading), .sensorOverrange(sensorOverrange),
    .alarmActive(alarmActive), .alarmDisplayOn(alarmDisplayOn), .msgAvailable(msgAvailable),
    .serialPoll(serialPoll), .statusByte(statusByte), .pollByte(pollByte), .srq(srq));

  ser_host_model ser_host_model_inst (
    .sys_clk(sys_clk), .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdDigits(cmdDigits),
    .respValid(respValid), .respDigits(respDigits));

  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;

  // =====================================================================
  // shared tasks
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic wr(input ser_cmd_t code, input int v);
    ser_host_model_inst.issue(code, v);
    chk1("respValid", 1'b0, respValid);
    step(1);
  endtask

  // a missing answer ends the run at once
  task automatic rd(input ser_cmd_t code, input logic [7:0] exp);
    logic [7:0] v;
    logic       ok;
    ser_host_model_inst.query(code, v, ok);
    chk1("respValid", 1'b1, ok);
    if (ok !== 1'b1) begin
      reportAndStop();
    end
    chk8(code.name(), exp, v);
    step(1);
  endtask

  initial begin
    #200000;
    errTotal++;
    $display("watchdog expired");
    reportAndStop();
  end

  // =====================================================================
  // main sequence
  initial begin
    {commandError, executionError, queryError, operationsPending, procCommFail} = '0;
    {calFault, tuningIdle, newReading, sensorOverrange, alarmActive} = '0;
    {alarmDisplayOn, msgAvailable, serialPoll} = '0;
    rst = 1'b1;
    step(4);
    chk8("statusByte", 8'h00, statusByte);
    chk1("srq", 1'b0, srq);
    rst = 1'b0;
    step(1);
    rd(SER_CMD_STD_EVENT_RD, 8'h80);
    rd(SER_CMD_STD_EVENT_RD, 8'h00);
    $display("test power_on done");

    foreach (rows[i]) begin
      wr(rows[i].wr, rows[i].val);
      rd(rows[i].rd, rows[i].exp);
    end
    $display("test mask_rows done");

    pulse(commandError);
    pulse(executionError);
    pulse(queryError);
    step(1);
    rd(SER_CMD_STD_EVENT_RD, 8'h34);
    wr(SER_CMD_STD_MASK_WR, 256);
    rd(SER_CMD_STD_MASK_RD, 8'h15);
    rd(SER_CMD_STD_EVENT_RD, 8'h10);
    operationsPending = 1'b1;
    wr(SER_CMD_OPC, 0);
    step(3);
    rd(SER_CMD_STD_EVENT_RD, 8'h00);
    operationsPending = 1'b0;
    step(2);
    rd(SER_CMD_STD_EVENT_RD, 8'h01);
    $display("test standard_events done");

    wr(SER_CMD_STD_MASK_WR, 32);
    pulse(commandError);
    step(3);
    chk8("statusByte", 8'h60, statusByte);
    chk1("srq", 1'b1, srq);
    pulse(serialPoll);
    step(2);
    chk1("srq", 1'b0, srq);
    chk8("statusByte", 8'h60, statusByte);
    chk8("pollByte", 8'h20, pollByte);
    rd(SER_CMD_STB_RD, 8'h60);
    rd(SER_CMD_STD_EVENT_RD, 8'h20);
    step(2);
    chk8("statusByte", 8'h00, statusByte);
    msgAvailable = 1'b1;
    step(3);
    chk8("statusByte", 8'h10, statusByte);
    msgAvailable = 1'b0;
    $display("test service_request done");

    {procCommFail, calFault, tuningIdle, newReading, sensorOverrange} = '1;
    {alarmActive, alarmDisplayOn} = '1;
    step(2);
    rd(SER_CMD_OP_COND_RD, 8'hf3);
    alarmDisplayOn = 1'b0;
    step(1);
    rd(SER_CMD_OP_COND_RD, 8'hf2);
    {procCommFail, calFault, tuningIdle, newReading, sensorOverrange, alarmActive} = '0;
    step(2);
    rd(SER_CMD_OP_COND_RD, 8'h00);
    rd(SER_CMD_OP_EVENT_RD, 8'hf3);
    rd(SER_CMD_OP_EVENT_RD, 8'h00);
    $display("test operation_set done");

    wr(SER_CMD_OP_MASK_WR, 16);
    wr(SER_CMD_SRQ_MASK_WR, 128);
    pulse(newReading);
    pulse(executionError);
    step(3);
    chk8("statusByte", 8'hc0, statusByte);
    chk1("srq", 1'b1, srq);
    wr(SER_CMD_CLS, 0);
    step(2);
    chk8("statusByte", 8'h00, statusByte);
    chk1("srq", 1'b0, srq);
    rd(SER_CMD_STD_EVENT_RD, 8'h00);
    rd(SER_CMD_OP_EVENT_RD, 8'h00);
    $display("test clear_status done");

    // reset in mid-run must drop the masks written above
    rst = 1'b1;
    step(2);
    chk8("statusByte", 8'h00, statusByte);
    rst = 1'b0;
    step(1);
    rd(SER_CMD_STD_MASK_RD, 8'h00);
    rd(SER_CMD_OP_MASK_RD, 8'h00);
    rd(SER_CMD_SRQ_MASK_RD, 8'h00);
    rd(SER_CMD_STD_EVENT_RD, 8'h80);
    $display("test mid_reset done");
    reportAndStop();
  end
endmodule
